// ---- hw/masb_status_bank.v ----
// masb_status_bank.v: read-only status bank of the motor algorithm,
// an APB slave with an event interrupt.
// assumes the algorithm logic runs on ref_clk_i and presents each
// variable as a whole word together with a one-cycle update strobe.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "masb_defs.vh"

module masb_status_bank (
   input  wire         ref_clk_i,   // system clock, 40 MHz
   input  wire         resetn_i,    // synchronous reset, active low
   // apb slave
   input  wire         psel_i,      // slave select
   input  wire         penable_i,   // access phase
   input  wire         pwrite_i,    // 1 = write
   input  wire [15:0]  paddr_i,     // byte address
   input  wire [31:0]  pwdata_i,    // write data
   output wire         pready_o,    // transfer done
   output wire [31:0]  prdata_o,    // read data
   output wire         pslverr_o,   // unmapped address
   // algorithm side, entry k occupies bits 32k+31..32k
   input  wire [543:0] var_data_i,  // new variable words
   input  wire [16:0]  var_upd_i,   // one-cycle update strobes
   // interrupt
   output wire         irq_o        // level, unmasked event pending
);

   // entry numbers inside the variable array
   localparam [4:0] E_STATE     = 5'h00;
   localparam [4:0] E_PSPEED    = 5'h01;
   localparam [4:0] E_BETA_AXIS_VOLTAGE     = 5'h02;
   localparam [4:0] E_ALIGN_IQ  = 5'h03;
   localparam [4:0] E_OL_SPEED  = 5'h04;
   localparam [4:0] E_OL_IQ     = 5'h05;
   localparam [4:0] E_CL_SPEED  = 5'h06;
   localparam [4:0] E_CL_ID     = 5'h07;
   localparam [4:0] E_CL_IQ     = 5'h08;
   localparam [4:0] E_SD_STATE  = 5'h09;
   localparam [4:0] E_SD_SPEED  = 5'h0A;
   localparam [4:0] E_PD_STATE  = 5'h0B;
   localparam [4:0] E_PD_ANGLE  = 5'h0C;
   localparam [4:0] E_EMF_D     = 5'h0D;
   localparam [4:0] E_EMF_Q     = 5'h0E;
   localparam [4:0] E_EST_SPEED = 5'h0F;
   localparam [4:0] E_EST_ANGLE = 5'h10;

   // held variable words, one per entry
   reg  [31:0] var_q [0:16];
   // interrupt status and mask
   reg  [3:0]  irq_stat_q;
   reg  [3:0]  irq_stat_d;
   reg  [3:0]  irq_mask_q;
   // registered bus answer
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg         slverr_q;
   reg         slverr_d;
   // decode results
   reg  [4:0]  sel_entry;   // entry addressed
   reg         sel_var;     // address hits a variable
   reg         sel_stat;    // address hits irq status
   reg         sel_mask;    // address hits irq mask
   // incoming state code and its checks
   wire [15:0] state_new;
   wire        state_ok;
   wire        state_take;
   wire [3:0]  irq_event;
   // bus phase helpers
   wire        setup_ph;
   wire        access_ph;
   wire [13:0] word_idx;
   wire        aligned;
   wire        wr_acc;

   assign setup_ph  = psel_i & ~penable_i;
   assign access_ph = psel_i & penable_i;
   assign word_idx  = paddr_i[15:2];
   assign aligned   = (paddr_i[1:0] == 2'h0);
   // writes act only at the completing edge of the access phase
   assign wr_acc    = access_ph & pwrite_i & ~slverr_q;

   // address decode; printed offsets are word indices
   always @* begin
      sel_entry = E_STATE;
      sel_var   = 1'b0;
      sel_stat  = 1'b0;
      sel_mask  = 1'b0;
      if (aligned) begin
         sel_var = 1'b1;
         case (word_idx)
            `MASB_IDX_STATE:     sel_entry = E_STATE;
            `MASB_IDX_PSPEED:    sel_entry = E_PSPEED;
            `MASB_IDX_BETA_AXIS_VOLTAGE:     sel_entry = E_BETA_AXIS_VOLTAGE;
            `MASB_IDX_ALIGN_IQ:  sel_entry = E_ALIGN_IQ;
            `MASB_IDX_OL_SPEED:  sel_entry = E_OL_SPEED;
            `MASB_IDX_OL_IQ:     sel_entry = E_OL_IQ;
            `MASB_IDX_CL_SPEED:  sel_entry = E_CL_SPEED;
            `MASB_IDX_CL_ID:     sel_entry = E_CL_ID;
            `MASB_IDX_CL_IQ:     sel_entry = E_CL_IQ;
            `MASB_IDX_SD_STATE:  sel_entry = E_SD_STATE;
            `MASB_IDX_SD_SPEED:  sel_entry = E_SD_SPEED;
            `MASB_IDX_PD_STATE:  sel_entry = E_PD_STATE;
            `MASB_IDX_PD_ANGLE:  sel_entry = E_PD_ANGLE;
            `MASB_IDX_EMF_D:     sel_entry = E_EMF_D;
            `MASB_IDX_EMF_Q:     sel_entry = E_EMF_Q;
            `MASB_IDX_EST_SPEED: sel_entry = E_EST_SPEED;
            `MASB_IDX_EST_ANGLE: sel_entry = E_EST_ANGLE;
            `MASB_IDX_IRQ_STAT: begin
               sel_var  = 1'b0;
               sel_stat = 1'b1;
            end
            `MASB_IDX_IRQ_MASK: begin
               sel_var  = 1'b0;
               sel_mask = 1'b1;
            end
            default: sel_var = 1'b0;   // reserved offset
         endcase
      end
   end

   // state code checks: only codes up to MASB_ST_LAST are taken, so a stray
   // value past it from the algorithm can never show as a state
   assign state_new  = var_data_i[15:0];
   assign state_ok   = (state_new <= `MASB_ST_LAST);
   assign state_take = var_upd_i[0] & state_ok;

   // variable storage: each word is loaded whole in one edge, so a
   // bus read that samples it can never see half an update
   genvar k;
   generate
      for (k = 1; k < `MASB_NVAR; k = k + 1) begin : g_var
         always @(posedge ref_clk_i) begin
            if (!resetn_i) begin
               var_q[k] <= `MASB_RST_VAR;
            end else if (var_upd_i[k]) begin
               var_q[k] <= var_data_i[32*k+31:32*k];
            end
         end
      end
   endgenerate

   // state code: upper half of the word is always zero
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         var_q[0] <= `MASB_RST_VAR;
      end else if (state_take) begin
         var_q[0] <= {16'h0000, state_new};
      end
   end

   // events seen on a state change
   assign irq_event[`MASB_IRQ_CHANGE] = state_take &
                                        (state_new != var_q[0][15:0]);
   assign irq_event[`MASB_IRQ_FAULT]  = irq_event[`MASB_IRQ_CHANGE] &
                                        (state_new == `MASB_ST_FAULT);
   assign irq_event[`MASB_IRQ_MDONE]  = irq_event[`MASB_IRQ_CHANGE] &
                                        (state_new == `MASB_ST_MEAS_DONE);
   assign irq_event[`MASB_IRQ_MFAULT] = irq_event[`MASB_IRQ_CHANGE] &
                                        (state_new == `MASB_ST_MEAS_FAULT);

   // sticky status: write one to clear, a new event wins over the clear
   always @* begin
      irq_stat_d = irq_stat_q;
      if (wr_acc & sel_stat) begin
         irq_stat_d = irq_stat_q & ~pwdata_i[3:0];
      end
      irq_stat_d = irq_stat_d | irq_event;
   end

   // interrupt status and mask registers
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         irq_stat_q <= `MASB_RST_IRQ;
         irq_mask_q <= `MASB_RST_IRQ;
      end else begin
         irq_stat_q <= irq_stat_d;
         if (wr_acc & sel_mask) begin
            irq_mask_q <= pwdata_i[3:0];
         end
      end
   end

   // read data and error are prepared in the setup phase; writes to
   // variables are accepted with no error and change nothing
   always @* begin
      rdata_d  = rdata_q;
      slverr_d = slverr_q;
      if (setup_ph) begin
         slverr_d = ~(sel_var | sel_stat | sel_mask);
         rdata_d  = 32'h00000000;
         if (!pwrite_i) begin
            if (sel_var) begin
               rdata_d = var_q[sel_entry];
            end else if (sel_stat) begin
               rdata_d = {28'h0000000, irq_stat_q};
            end else if (sel_mask) begin
               rdata_d = {28'h0000000, irq_mask_q};
            end
         end
      end
   end

   // bus answer registers
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rdata_q  <= 32'h00000000;
         slverr_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         slverr_q <= slverr_d;
      end
   end

   // outputs: one access cycle, never a wait state
   assign pready_o  = access_ph;
   assign prdata_o  = rdata_q;
   assign pslverr_o = access_ph & slverr_q;
   assign irq_o     = |(irq_stat_q & irq_mask_q);

endmodule // masb_status_bank
`default_nettype wire

// ---- hw/masb_defs.vh ----
// masb_defs.vh: constants of the motor algorithm status bank.
// assumes it is included by its bare name from the design file.
`ifndef MASB_DEFS_VH
`define MASB_DEFS_VH

// number of algorithm variables held by the bank
`define MASB_NVAR          17
// register indices; byte address on the bus is four times the index
`define MASB_IDX_STATE     14'h018E
`define MASB_IDX_PSPEED    14'h0194
`define MASB_IDX_BETA_AXIS_VOLTAGE     14'h0400
`define MASB_IDX_ALIGN_IQ  14'h052A
`define MASB_IDX_OL_SPEED  14'h0540
`define MASB_IDX_OL_IQ     14'h0550
`define MASB_IDX_CL_SPEED  14'h05D2
`define MASB_IDX_CL_ID     14'h0612
`define MASB_IDX_CL_IQ     14'h0614
`define MASB_IDX_SD_STATE  14'h06AE
`define MASB_IDX_SD_SPEED  14'h06B8
`define MASB_IDX_PD_STATE  14'h06EA
`define MASB_IDX_PD_ANGLE  14'h072E
`define MASB_IDX_EMF_D     14'h0772
`define MASB_IDX_EMF_Q     14'h0774
`define MASB_IDX_EST_SPEED 14'h0782
`define MASB_IDX_EST_ANGLE 14'h0786
// interrupt status and mask registers
`define MASB_IDX_IRQ_STAT  14'h07F0
`define MASB_IDX_IRQ_MASK  14'h07F1

// reset values
`define MASB_RST_VAR       32'h00000000
`define MASB_RST_IRQ       4'h0

// width of the operating state code
`define MASB_STATE_W       16
// operating state codes
`define MASB_ST_IDLE       16'h0000
`define MASB_ST_FAULT      16'h000E
`define MASB_ST_MEAS_DONE  16'h0017
`define MASB_ST_MEAS_FAULT 16'h0018
`define MASB_ST_LAST       16'h0018

// interrupt status bit positions
`define MASB_IRQ_W         4
`define MASB_IRQ_CHANGE    0
`define MASB_IRQ_FAULT     1
`define MASB_IRQ_MDONE     2
`define MASB_IRQ_MFAULT    3

`endif

// ---- tb/masb_status_bank_sva.sv ----
// masb_status_bank_sva.sv: port assertions for the status bank.
// assumes only the bank's own ports and its single clock.
`timescale 1ns/10ps
`default_nettype none
`include "masb_defs.vh"
module masb_status_bank_sva (
   input wire logic        ref_clk_i,
   input wire logic        resetn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // access phase of any transfer
   wire acc = psel_i && penable_i;
   // zero wait states: answer in the first access cycle
   zero_wait_a: assert property (psel_i && !penable_i ##1 acc |-> pready_o)
      else $error("no ready in first access cycle");
   idle_ready_a: assert property (!psel_i |-> !pready_o)
      else $error("ready without select");
   // nothing pending and nothing read back right after reset
   reset_quiet_a: assert property ($rose(resetn_i) |-> !irq_o && prdata_o == 32'h0)
      else $error("bank not quiet after reset");
   misalign_err_a: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("misaligned access not refused");
   err_no_data_a: assert property (pslverr_o |-> acc && prdata_o == 32'h0)
      else $error("error outside access or with data");
   write_no_data_a: assert property (acc && pwrite_i |-> prdata_o == 32'h0)
      else $error("read data during write");
   // a state read never shows a code past the last one
   state_range_a: assert property (
      acc && !pwrite_i && paddr_i == {`MASB_IDX_STATE, 2'h0} |-> prdata_o <= 32'h18)
      else $error("state code out of range");
   var_write_ok_a: assert property (
      acc && pwrite_i && paddr_i == {`MASB_IDX_PSPEED, 2'h0} |-> !pslverr_o)
      else $error("write to variable refused");
endmodule // masb_status_bank_sva
bind masb_status_bank masb_status_bank_sva u_sva (.ref_clk_i, .resetn_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o, .irq_o);
`default_nettype wire

// ---- tb/motor_algorithm_status_bank_bench.sv ----
// motor_algorithm_status_bank_bench.sv: self-checking bench of the bank.
// assumes the checker file is compiled first and binds itself.
`timescale 1ns/10ps
`default_nettype none
`include "masb_defs.vh"
module motor_algorithm_status_bank_bench;
   logic         ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i, er;
   logic [15:0]  paddr_i;
   logic [31:0]  pwdata_i, rd;
   logic [543:0] var_data_i;
   logic [16:0]  var_upd_i, pend;   // pend: strobes raised with next setup
   wire          pready_o, pslverr_o, irq_o;
   wire  [31:0]  prdata_o;
   int           bad_count, samples_checked;
   masb_status_bank u_dut (.ref_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .var_data_i, .var_upd_i, .irq_o);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer; pending strobes ride on the setup cycle
   task apb(input logic w, input logic [13:0] idx, input logic [1:0] lo, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i    <= 1'h1;
      pwrite_i  <= w;
      paddr_i   <= {idx, lo};
      pwdata_i  <= d;
      var_upd_i <= pend;
      pend = 17'h0;
      @(posedge ref_clk_i);
      penable_i <= 1'h1;
      var_upd_i <= 17'h0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'h1 && n < 20);
      if (n >= 20) bad_count++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task rdchk(input logic [13:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 2'h0, 32'h0);
      chk(rd, exp);
   endtask
   // one-cycle update strobe for entry k
   task upd(input int k, input logic [31:0] v);
      @(posedge ref_clk_i);
      var_data_i[32*k +: 32] <= v;
      var_upd_i[k] <= 1'h1;
      @(posedge ref_clk_i);
      var_upd_i <= 17'h0;
   endtask
   task reset_for(input int n);
      resetn_i <= 1'h0;
      repeat (n) @(posedge ref_clk_i);
      resetn_i <= 1'h1;
   endtask
   task t_reset;
      rdchk(`MASB_IDX_STATE, 32'h0);
      rdchk(`MASB_IDX_PSPEED, 32'h0);
      rdchk(`MASB_IDX_BETA_AXIS_VOLTAGE, 32'h0);
      rdchk(`MASB_IDX_IRQ_MASK, 32'h0);
      chk(irq_o, 32'h0);
   endtask
   // walk state codes 1 to 0x18 (idle is the reset value), then the events they raise
   task t_codes;
      for (int c = 1; c <= 32'h18; c++) begin
         upd(0, c);
         rdchk(`MASB_IDX_STATE, c);
      end
      rdchk(`MASB_IDX_IRQ_STAT, 32'hF);
      chk(irq_o, 32'h0);
      // writes land at the completing edge: look at irq_o once it settled
      apb(1'h1, `MASB_IDX_IRQ_MASK, 2'h0, 32'h2);
      @(negedge ref_clk_i);
      chk(irq_o, 32'h1);
      apb(1'h1, `MASB_IDX_IRQ_STAT, 2'h0, 32'hF);
      @(negedge ref_clk_i);
      chk(irq_o, 32'h0);
      upd(0, 32'h19);
      rdchk(`MASB_IDX_STATE, 32'h18);
      rdchk(`MASB_IDX_IRQ_STAT, 32'h0);
      upd(0, 32'hE);
      rdchk(`MASB_IDX_IRQ_STAT, 32'h3);
      @(negedge ref_clk_i);
      chk(irq_o, 32'h1);
   endtask
   task t_words;
      upd(1, 32'hFFFFFFFF);
      upd(2, 32'h80000001);
      rdchk(`MASB_IDX_PSPEED, 32'hFFFFFFFF);
      rdchk(`MASB_IDX_BETA_AXIS_VOLTAGE, 32'h80000001);
      apb(1'h1, `MASB_IDX_PSPEED, 2'h0, 32'h0);
      chk(er, 32'h0);
      rdchk(`MASB_IDX_PSPEED, 32'hFFFFFFFF);
      // reserved offset is only ever read, never written
      apb(1'h0, 14'h0002, 2'h0, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'h0, `MASB_IDX_PSPEED, 2'h1, 32'h0);
      chk(er, 32'h1);
      // update lands on the setup edge: old word must come back whole
      @(posedge ref_clk_i);
      var_data_i[95:64] <= 32'h12345678;
      pend = 17'h4;
      rdchk(`MASB_IDX_BETA_AXIS_VOLTAGE, 32'h80000001);
      rdchk(`MASB_IDX_BETA_AXIS_VOLTAGE, 32'h12345678);
   endtask
   initial begin
      ref_clk_i = 1'h0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {var_data_i, var_upd_i, pend, bad_count, samples_checked} = '0;
      reset_for(8);
      t_reset;
      t_codes;
      t_words;
      reset_for(2);
      t_reset;
      results;
   end
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #200000;
      bad_count++;
      results;
   end
endmodule // motor_algorithm_status_bank_bench
`default_nettype wire
